// >>> core/lsmu_consts.vh
// Opcode fields, format codes, select masks and transfer sizes of the data-movement unit
`ifndef LSMU_CONSTS_VH
`define LSMU_CONSTS_VH

// Opcode bits [7:6]: instruction format
`define FMT_MSB 7
`define FMT_LSB 6
`define FMT_ADDRESSING 2'h2
`define FMT_THREE_OPERAND 2'h1

// Addressing format: [5:4] size class, [3:2] words minus one, [1] signed, [0] store
`define SZ_MSB 5
`define SZ_LSB 4
`define SZ_BYTE 2'h0
`define SZ_HALF 2'h1
`define SZ_WORDS 2'h2
`define SZ_EA 2'h3
`define WCNT_MSB 3
`define WCNT_LSB 2
`define SIGNED_BIT 1
`define STORE_BIT 0

// Three-operand format: [5:4] class; copy uses [1:0] words minus one, select uses [2:0] mask
`define CLS_COPY 2'h0
`define CLS_SELECT 2'h1
`define CNT_MSB 1
`define CNT_LSB 0
`define MASK_MSB 2
`define MASK_LSB 0

// Select condition masks
`define PICK_UNORDERED 3'h0
`define PICK_GREATER 3'h1
`define PICK_EQUAL 3'h2
`define PICK_GREATER_EQUAL 3'h3
`define PICK_LESS 3'h4
`define PICK_NOT_EQUAL 3'h5
`define PICK_LESS_EQUAL 3'h6
`define PICK_ORDERED 3'h7

// Bytes per word and reset value of the sticky overflow flag
`define WORD_BYTES 32'h4
`define OVF_FLAG_RESET 1'h0

`endif

// >>> core/narrow_store_check.v
// Narrowing of a 32-bit register value for byte and half-word stores, with overflow check
`timescale 1ns/1ps
module narrow_store_check (
  // Source value and store shape
  input wire [31:0] value,
  input wire half,
  input wire signed_store,
  // Narrowed value in the low bits and overflow indication
  output wire [31:0] narrowed,
  output wire overflow
);
  wire byte_fits;
  wire half_fits;

  // Fits when the dropped upper bits all copy the new sign bit
  assign byte_fits = (value[31:7] == {25{1'b0}}) || (value[31:7] == {25{1'b1}});
  assign half_fits = (value[31:15] == {17{1'b0}}) || (value[31:15] == {17{1'b1}});
  assign narrowed = half ? {16'h0000, value[15:0]} : {24'h000000, value[7:0]};
  // Truncating stores never report loss of significant bits
  assign overflow = signed_store & (half ? ~half_fits : ~byte_fits);
endmodule

// >>> core/load_store_move_select_unit.v
// Data-movement datapath: loads, stores, register copies, address load and conditional select
`timescale 1ns/1ps
`include "lsmu_consts.vh"
module load_store_move_select_unit #(
  parameter REG_AW = 5
) (
  // Clock and reset
  input wire SYS_CLK,
  input wire RST_N,
  // Operation request
  input wire OP_VALID,
  input wire [7:0] OP_CODE,
  input wire [REG_AW-1:0] OP_DST,
  input wire [REG_AW-1:0] OP_SRC1,
  input wire [REG_AW-1:0] OP_SRC2,
  input wire [31:0] OP_BASE,
  input wire [31:0] OP_OFFSET,
  output reg OP_BUSY,
  output reg OP_DONE,
  output reg OP_ILLEGAL,
  // Arithmetic controls
  input wire [2:0] CC_IN,
  input wire OVF_MASK,
  input wire OVF_CLR,
  output reg OVF_FLAG,
  output reg OVF_FAULT,
  // Register file
  output reg [REG_AW-1:0] RF_RADDR,
  input wire [31:0] RF_RDATA,
  output reg RF_WE,
  output reg [REG_AW-1:0] RF_WADDR,
  output reg [31:0] RF_WDATA,
  // Memory access path
  output reg MEM_REQ,
  output reg MEM_WE,
  output reg [31:0] MEM_ADDR,
  output reg [3:0] MEM_BE,
  output reg [31:0] MEM_WDATA,
  input wire MEM_ACK,
  input wire [31:0] MEM_RDATA
);
  localparam S_IDLE = 3'h0;
  localparam S_RREQ = 3'h1;
  localparam S_RDAT = 3'h2;
  localparam S_MEM = 3'h3;
  localparam S_WRITE = 3'h4;

  reg [2:0] state_r;
  reg [7:0] op_r;
  reg [REG_AW-1:0] dst_r;
  reg [REG_AW-1:0] src_r;
  reg [31:0] ea_r;
  reg [1:0] cnt_r;
  reg [1:0] last_r;

  wire [1:0] fmt;
  wire [1:0] sz;
  wire is_store;
  wire is_signed;
  wire is_mem;
  wire is_load;
  wire is_copy;
  wire is_select;
  wire is_ea;
  wire cond_met;
  wire legal;
  wire [31:0] narrowed;
  wire narrow_ovf;
  wire [31:0] ea_now;
  wire is_last;

  // Register index i words past a base; stays inside its local or global bank
  function [REG_AW-1:0] reg_step;
    input [REG_AW-1:0] base;
    input [1:0] step;
    begin
      reg_step = {base[REG_AW-1:2], base[1:0] + step};
    end
  endfunction

  // Byte lane enables for an access of the given size class at an address
  function [3:0] lane_mask;
    input [1:0] size;
    input [1:0] low;
    begin
      case (size)
        `SZ_BYTE: lane_mask = 4'h1 << low;
        `SZ_HALF: lane_mask = low[1] ? 4'hc : 4'h3;
        default: lane_mask = 4'hf;
      endcase
    end
  endfunction

  // Pick the addressed byte or half of a fetched word and widen it
  function [31:0] widen;
    input [31:0] word;
    input [1:0] size;
    input sgn;
    input [1:0] low;
    reg [31:0] sh;
    begin
      sh = word >> {low, 3'h0};
      case (size)
        `SZ_BYTE: widen = {{24{sgn & sh[7]}}, sh[7:0]};
        `SZ_HALF: widen = {{16{sgn & sh[15]}}, sh[15:0]};
        default: widen = word;
      endcase
    end
  endfunction

  assign fmt = OP_CODE[`FMT_MSB:`FMT_LSB];
  assign sz = OP_CODE[`SZ_MSB:`SZ_LSB];
  assign is_mem = fmt == `FMT_ADDRESSING;
  assign is_ea = is_mem && sz == `SZ_EA;
  // Each load shape has its store twin through the store bit alone
  assign is_load = is_mem && !is_ea && !OP_CODE[`STORE_BIT];
  assign is_copy = fmt == `FMT_THREE_OPERAND && sz == `CLS_COPY;
  assign is_select = fmt == `FMT_THREE_OPERAND && sz == `CLS_SELECT;
  assign cond_met = (OP_CODE[`MASK_MSB:`MASK_LSB] & CC_IN) != 3'h0;
  assign legal = is_mem || is_copy || is_select;
  assign ea_now = OP_BASE + OP_OFFSET;

  assign is_store = op_r[`STORE_BIT];
  assign is_signed = op_r[`SIGNED_BIT];
  assign is_last = cnt_r == last_r;

  narrow_store_check u_narrow (
    .value(RF_RDATA),
    .half(op_r[`SZ_MSB:`SZ_LSB] == `SZ_HALF),
    .signed_store(is_signed),
    .narrowed(narrowed),
    .overflow(narrow_ovf)
  );

  // Sticky flag; a new overflow in the clearing cycle wins
  wire ovf_set;
  assign ovf_set = state_r == S_RDAT && op_r[`FMT_MSB:`FMT_LSB] == `FMT_ADDRESSING && is_store &&
                   op_r[`SZ_MSB] == 1'b0 && narrow_ovf && OVF_MASK;

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      OVF_FLAG <= `OVF_FLAG_RESET;
    end else if (ovf_set) begin
      OVF_FLAG <= 1'b1;
    end else if (OVF_CLR) begin
      OVF_FLAG <= 1'b0;
    end
  end

  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= S_IDLE;
      op_r <= 8'h00;
      dst_r <= {REG_AW{1'b0}};
      src_r <= {REG_AW{1'b0}};
      ea_r <= 32'h00000000;
      cnt_r <= 2'h0;
      last_r <= 2'h0;
      OP_BUSY <= 1'b0;
      OP_DONE <= 1'b0;
      OP_ILLEGAL <= 1'b0;
      OVF_FAULT <= 1'b0;
      RF_RADDR <= {REG_AW{1'b0}};
      RF_WE <= 1'b0;
      RF_WADDR <= {REG_AW{1'b0}};
      RF_WDATA <= 32'h00000000;
      MEM_REQ <= 1'b0;
      MEM_WE <= 1'b0;
      MEM_ADDR <= 32'h00000000;
      MEM_BE <= 4'h0;
      MEM_WDATA <= 32'h00000000;
    end else begin
      OP_DONE <= 1'b0;
      OP_ILLEGAL <= 1'b0;
      OVF_FAULT <= 1'b0;
      RF_WE <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (OP_VALID) begin
            op_r <= OP_CODE;
            dst_r <= OP_DST;
            cnt_r <= 2'h0;
            ea_r <= ea_now;
            // Select reduces to a one-word copy of the chosen source
            src_r <= (is_select && !cond_met) ? OP_SRC2 : OP_SRC1;
            if (!legal) begin
              OP_ILLEGAL <= 1'b1;
              OP_DONE <= 1'b1;
            end else if (is_ea) begin
              RF_WE <= 1'b1;
              RF_WADDR <= OP_DST;
              RF_WDATA <= ea_now;
              OP_DONE <= 1'b1;
            end else begin
              OP_BUSY <= 1'b1;
              if (is_mem && sz == `SZ_WORDS) begin
                last_r <= OP_CODE[`WCNT_MSB:`WCNT_LSB];
              end else if (is_copy) begin
                last_r <= OP_CODE[`CNT_MSB:`CNT_LSB];
              end else begin
                last_r <= 2'h0;
              end
              if (is_load) begin
                MEM_REQ <= 1'b1;
                MEM_WE <= 1'b0;
                MEM_ADDR <= ea_now;
                MEM_BE <= lane_mask(sz, ea_now[1:0]);
                state_r <= S_MEM;
              end else begin
                RF_RADDR <= (is_select && !cond_met) ? OP_SRC2 : OP_SRC1;
                state_r <= S_RDAT;
              end
            end
          end
        end
        S_RREQ: begin
          RF_RADDR <= reg_step(src_r, cnt_r);
          state_r <= S_RDAT;
        end
        S_RDAT: begin
          if (op_r[`FMT_MSB:`FMT_LSB] == `FMT_ADDRESSING) begin
            if (op_r[`SZ_MSB] == 1'b0 && narrow_ovf && !OVF_MASK) begin
              // Faulting store leaves memory untouched
              OVF_FAULT <= 1'b1;
              OP_DONE <= 1'b1;
              OP_BUSY <= 1'b0;
              state_r <= S_IDLE;
            end else begin
              MEM_REQ <= 1'b1;
              MEM_WE <= 1'b1;
              MEM_ADDR <= ea_r + (`WORD_BYTES * cnt_r);
              MEM_BE <= lane_mask(op_r[`SZ_MSB:`SZ_LSB], ea_r[1:0]);
              if (op_r[`SZ_MSB] == 1'b0) begin
                // Narrow value copied into every lane; byte enables pick the target
                MEM_WDATA <= op_r[`SZ_LSB] ? {2{narrowed[15:0]}} : {4{narrowed[7:0]}};
              end else begin
                MEM_WDATA <= RF_RDATA;
              end
              state_r <= S_MEM;
            end
          end else begin
            RF_WE <= 1'b1;
            RF_WADDR <= reg_step(dst_r, cnt_r);
            RF_WDATA <= RF_RDATA;
            state_r <= S_WRITE;
          end
        end
        S_MEM: begin
          if (MEM_ACK) begin
            MEM_REQ <= 1'b0;
            MEM_WE <= 1'b0;
            if (!is_store) begin
              RF_WE <= 1'b1;
              RF_WADDR <= reg_step(dst_r, cnt_r);
              RF_WDATA <= widen(MEM_RDATA, op_r[`SZ_MSB:`SZ_LSB], is_signed, ea_r[1:0]);
              state_r <= S_WRITE;
            end else if (is_last) begin
              OP_DONE <= 1'b1;
              OP_BUSY <= 1'b0;
              state_r <= S_IDLE;
            end else begin
              cnt_r <= cnt_r + 2'h1;
              state_r <= S_RREQ;
            end
          end
        end
        S_WRITE: begin
          if (is_last) begin
            OP_DONE <= 1'b1;
            OP_BUSY <= 1'b0;
            state_r <= S_IDLE;
          end else if (op_r[`FMT_MSB:`FMT_LSB] == `FMT_ADDRESSING) begin
            cnt_r <= cnt_r + 2'h1;
            MEM_REQ <= 1'b1;
            MEM_WE <= 1'b0;
            MEM_ADDR <= ea_r + (`WORD_BYTES * (cnt_r + 2'h1));
            MEM_BE <= 4'hf;
            state_r <= S_MEM;
          end else begin
            cnt_r <= cnt_r + 2'h1;
            state_r <= S_RREQ;
          end
        end
        default: begin
          state_r <= S_IDLE;
          OP_BUSY <= 1'b0;
          MEM_REQ <= 1'b0;
        end
      endcase
    end
  end
endmodule

// >>> bench/lsmu_far_side.sv
// Register file and memory path model facing the data-movement unit
`timescale 1ns/1ps
module lsmu_far_side (
  // Clock
  input wire clk,
  // Register file side
  input wire [4:0] raddr,
  output logic [31:0] rdata,
  input wire we,
  input wire [4:0] waddr,
  input wire [31:0] wdata,
  // Memory side
  input wire req,
  input wire mwe,
  input wire [31:0] addr,
  input wire [3:0] be,
  input wire [31:0] mwdata,
  output logic ack,
  output logic [31:0] mrdata,
  input wire [1:0] lat
);
  logic [31:0] rf [0:31];
  logic [31:0] mem [0:63];
  logic [1:0] cnt = 2'h0;
  int b;
  initial ack = 1'b0;
  initial mrdata = 32'h0;
  // Read is asynchronous: the unit takes the data at the edge after it sets the address
  assign rdata = rf[raddr];
  always @(posedge clk) begin
    if (we) rf[waddr] <= wdata;
    ack <= 1'b0;
    // Read data is not held after the ack, so stale values cannot pass
    mrdata <= ~mrdata;
    if (req && !ack) begin
      if (cnt == lat) begin
        ack <= 1'b1;
        cnt <= 2'h0;
        if (!mwe) mrdata <= mem[addr[7:2]];
        else for (b = 0; b < 4; b++) if (be[b]) mem[addr[7:2]][8*b +: 8] <= mwdata[8*b +: 8];
      end else cnt <= cnt + 2'h1;
    end
  end
endmodule

// >>> bench/load_store_move_select_unit_sva.sv
// Port checker for the data-movement unit
`timescale 1ns/1ps
module lsmu_checker #(parameter REG_AW = 5) (
  input wire SYS_CLK, input wire RST_N, input wire OP_VALID, input wire [7:0] OP_CODE,
  input wire [REG_AW-1:0] OP_DST, input wire [REG_AW-1:0] OP_SRC1, input wire [REG_AW-1:0] OP_SRC2,
  input wire [31:0] OP_BASE, input wire [31:0] OP_OFFSET, input wire OP_BUSY, input wire OP_DONE,
  input wire OP_ILLEGAL, input wire [2:0] CC_IN, input wire OVF_MASK, input wire OVF_CLR, input wire OVF_FLAG,
  input wire OVF_FAULT, input wire [REG_AW-1:0] RF_RADDR, input wire [31:0] RF_RDATA, input wire RF_WE,
  input wire [REG_AW-1:0] RF_WADDR, input wire [31:0] RF_WDATA, input wire MEM_REQ, input wire MEM_WE,
  input wire [31:0] MEM_ADDR, input wire [3:0] MEM_BE, input wire [31:0] MEM_WDATA, input wire MEM_ACK,
  input wire [31:0] MEM_RDATA
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  wire acc = OP_VALID && !OP_BUSY && !OP_DONE;
  sequence s_acc_sel; acc && OP_CODE[7:3] == 5'h0a; endsequence
  sequence s_rd_ack; MEM_REQ && MEM_ACK && !MEM_WE; endsequence
  property p_done; OP_DONE |=> !OP_DONE; endproperty
  property p_ill; OP_ILLEGAL |-> OP_DONE && !RF_WE && !MEM_REQ; endproperty
  property p_flt; OVF_FAULT |-> OP_DONE && !MEM_REQ; endproperty
  property p_hold; MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WDATA) && $stable(MEM_BE);
  endproperty
  property p_wr; MEM_REQ && MEM_WE && MEM_ACK |=> !MEM_REQ; endproperty
  property p_ld; s_rd_ack |=> RF_WE; endproperty
  property p_ea; acc && OP_CODE[7:4] == 4'hb |=> RF_WE && OP_DONE && RF_WDATA == $past(OP_BASE) + $past(OP_OFFSET);
  endproperty
  property p_sel;
    s_acc_sel |=> RF_RADDR == ((|($past(OP_CODE[2:0]) & $past(CC_IN))) ? $past(OP_SRC1) : $past(OP_SRC2));
  endproperty
  property p_sticky; OVF_FLAG && !OVF_CLR |=> OVF_FLAG; endproperty
  a_done: assert property (p_done) else $error("done longer than one cycle");
  a_ill: assert property (p_ill) else $error("illegal op had side effects");
  a_flt: assert property (p_flt) else $error("fault with memory access");
  a_hold: assert property (p_hold) else $error("memory request changed before ack");
  a_wr: assert property (p_wr) else $error("write request held after ack");
  a_ld: assert property (p_ld) else $error("no register write after load data");
  a_ea: assert property (p_ea) else $error("address load result wrong");
  a_sel: assert property (p_sel) else $error("select read wrong source");
  a_sticky: assert property (p_sticky) else $error("overflow flag dropped");
endmodule
bind load_store_move_select_unit lsmu_checker #(.REG_AW(REG_AW)) chk_i (.*);

// >>> bench/load_store_move_select_unit_tb.sv
// Self-checking bench of the data-movement unit
`timescale 1ns/1ps
module load_store_move_select_unit_tb;
  logic SYS_CLK = 0, RST_N = 0, OP_VALID = 0, OVF_MASK = 0, OVF_CLR = 0, ill, flt;
  logic [7:0] OP_CODE = 0;
  logic [4:0] OP_DST = 0, OP_SRC1 = 0, OP_SRC2 = 0, rra, rwa;
  logic [31:0] OP_BASE = 0, OP_OFFSET = 0, rrd, rwd, ma, mwd, mrd;
  logic [2:0] CC_IN = 0;
  logic [3:0] mbe;
  logic [1:0] lat = 0;
  wire busy, done, illg, flag, fault, rwe, mreq, mwe, mack;
  int n_fail = 0, checked = 0, i;
  always #25 SYS_CLK = ~SYS_CLK;
  load_store_move_select_unit uut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
    .OP_DST(OP_DST), .OP_SRC1(OP_SRC1), .OP_SRC2(OP_SRC2), .OP_BASE(OP_BASE), .OP_OFFSET(OP_OFFSET),
    .OP_BUSY(busy), .OP_DONE(done), .OP_ILLEGAL(illg), .CC_IN(CC_IN), .OVF_MASK(OVF_MASK), .OVF_CLR(OVF_CLR),
    .OVF_FLAG(flag), .OVF_FAULT(fault), .RF_RADDR(rra), .RF_RDATA(rrd), .RF_WE(rwe), .RF_WADDR(rwa),
    .RF_WDATA(rwd), .MEM_REQ(mreq), .MEM_WE(mwe), .MEM_ADDR(ma), .MEM_BE(mbe), .MEM_WDATA(mwd),
    .MEM_ACK(mack), .MEM_RDATA(mrd));
  lsmu_far_side fs (.clk(SYS_CLK), .raddr(rra), .rdata(rrd), .we(rwe), .waddr(rwa), .wdata(rwd), .req(mreq),
    .mwe(mwe), .addr(ma), .be(mbe), .mwdata(mwd), .ack(mack), .mrdata(mrd), .lat(lat));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One operation; returns at the edge where the done pulse is sampled
  task automatic run(input [7:0] op, input [4:0] d, input [4:0] s1, input [4:0] s2, input [31:0] b,
                     input [31:0] off);
    int k;
    OP_CODE <= op; OP_DST <= d; OP_SRC1 <= s1; OP_SRC2 <= s2; OP_BASE <= b; OP_OFFSET <= off; OP_VALID <= 1;
    @(posedge SYS_CLK);
    OP_VALID <= 0;
    for (k = 0; k < 300 && done !== 1'b1; k++) @(posedge SYS_CLK);
    ill = illg;
    flt = fault;
    chk("done", done, 1);
  endtask
  task automatic t_move;
    run(8'h43, 16, 8, 0, 0, 0);
    for (i = 0; i < 4; i++) chk("copy", fs.rf[16+i], 32'ha5000008 + i);
    run(8'hac, 4, 4, 0, 32'h10, 0);
    for (i = 0; i < 4; i++) chk("load", fs.rf[4+i], 32'h5a000000 + i);
    for (i = 0; i < 4; i++) begin
      run({2'h2, 1'b0, i[1], 2'h0, i[0], 1'b0}, 1, 1, 0, i[1] ? 6 : 7, 0);
      chk("widen", fs.rf[1], i[1] ? {{16{i[0]}}, 16'h80f0} : {{24{i[0]}}, 8'h80});
    end
  endtask
  task automatic t_store;
    lat <= 2;
    run(8'had, 8, 8, 0, 32'h40, 0);
    for (i = 0; i < 4; i++) chk("store", fs.mem[16+i], 32'ha5000008 + i);
    run(8'h81, 2, 2, 0, 32'h52, 0);
    chk("trunc_fault", flt, 0);
    chk("trunc", fs.mem[20], 32'h00020000);
    run(8'h83, 2, 2, 0, 32'h58, 0);
    chk("fault", flt, 1);
    chk("fault_flag", flag, 0);
    chk("fault_mem", fs.mem[22], 32'h00000000);
    OVF_MASK <= 1;
    run(8'h83, 2, 2, 0, 32'h58, 0);
    run(8'hb0, 3, 3, 0, 32'h12340000, 32'h5678);
    chk("flag", {flt, flag}, 2'h1);
    chk("masked", fs.mem[22], 32'h00000002);
    // The register file takes the write of an address load at the same edge where run samples its done pulse
    @(posedge SYS_CLK);
    chk("ea", fs.rf[3], 32'h12345678);
    OVF_CLR <= 1;
    @(posedge SYS_CLK);
    OVF_CLR <= 0;
    @(posedge SYS_CLK);
    chk("clear", flag, 0);
  endtask
  task automatic t_sel;
    CC_IN <= 3'h2;
    for (i = 0; i < 8; i++) begin
      run({5'h0a, i[2:0]}, 20, 1, 2, 0, 0);
      chk("select", fs.rf[20], i[1] ? 32'hffff80f0 : 32'ha5000002);
    end
    run(8'h00, 0, 0, 0, 0, 0);
    chk("illegal", ill, 1);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    for (i = 0; i < 32; i++) fs.rf[i] = 32'ha5000000 + i;
    for (i = 0; i < 64; i++) fs.mem[i] = (i >= 4 && i < 8) ? 32'h5a000000 + i - 4 : 0;
    fs.mem[1] = 32'h80f07f85;
    repeat (6) @(posedge SYS_CLK);
    RST_N <= 1;
    @(posedge SYS_CLK);
    t_move;
    t_store;
    t_sel;
    summarize;
  end
  initial begin
    #200000;
    n_fail++;
    summarize;
  end
endmodule
